//--- hdl/usb_jtag_pkg.sv
// constants, states and descriptor table of the usb-to-jtag bridge
package usb_jtag_pkg;

   localparam int BYTE_W = 8;
   localparam int DIV_W = 8;
   localparam int BUF_AW = 6;
   localparam int MEM_AW = 7;
   localparam int REP_W = 32;

   localparam logic [7:0] DIV_RESET = 8'h02;
   localparam logic [6:0] BUF_BYTES = 7'h40;
   localparam logic [3:0] REP_DEPTH_MAX = 4'he;
   localparam logic [3:0] LAST_RESET = 4'hb;

   // nibble encodings and field positions
   localparam int NIB_TDI = 0;
   localparam int NIB_TMS = 1;
   localparam int NIB_CAP = 2;
   localparam int NIB_CLASS = 3;
   localparam logic [2:0] NIB_RST_TOP = 3'h4;
   localparam logic [3:0] NIB_FLUSH = 4'ha;
   localparam logic [1:0] NIB_REP_TOP = 2'h3;

   // control requests
   localparam logic [7:0] RT_VEND_OUT = 8'h40;
   localparam logic [7:0] RT_VEND_IN = 8'hc0;
   localparam logic [7:0] RT_STD_IN = 8'h80;
   localparam logic [7:0] REQ_SET_DIV = 8'h00;
   localparam logic [7:0] REQ_SET_IO = 8'h01;
   localparam logic [7:0] REQ_GET_TDO = 8'h02;
   localparam logic [7:0] REQ_GET_DESC = 8'h06;
   localparam logic [15:0] DESC_JTAG_CAP = 16'h2000;
   localparam int IO_TDI = 0;
   localparam int IO_TMS = 1;
   localparam int IO_TCK = 2;
   localparam int IO_TRST = 3;
   localparam int IO_SRST = 4;

   // capabilities descriptor
   localparam logic [7:0] DESC_VERSION = 8'h01;
   localparam logic [7:0] DESC_LEN = 8'h0a;
   localparam logic [7:0] SPEED_TYPE = 8'h01;
   localparam logic [7:0] SPEED_LEN = 8'h08;
   localparam logic [15:0] BUS_SPEED_10KHZ = 16'h1f40;
   localparam logic [15:0] DIVISOR_MIN = 16'h0001;
   localparam logic [15:0] DIVISOR_MAX = 16'h00ff;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b001,
      ST_DECODE = 3'b010,
      ST_RUN = 3'b100
   } exec_state_e;

   function automatic logic [7:0] desc_byte(input logic [7:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         8'h00: b = DESC_VERSION;
         8'h01: b = DESC_LEN;
         8'h02: b = SPEED_TYPE;
         8'h03: b = SPEED_LEN;
         8'h04: b = BUS_SPEED_10KHZ[7:0];
         8'h05: b = BUS_SPEED_10KHZ[15:8];
         8'h06: b = DIVISOR_MIN[7:0];
         8'h07: b = DIVISOR_MIN[15:8];
         8'h08: b = DIVISOR_MAX[7:0];
         8'h09: b = DIVISOR_MAX[15:8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction : desc_byte

   function automatic logic [REP_W-1:0] rep_count(input logic [1:0] r, input logic [3:0] depth);
      return {30'h0, r} << {depth, 1'b0};
   endfunction : rep_count

endpackage : usb_jtag_pkg

//--- hdl/capture_mem_if.sv
// write and read port of the capture buffer memory
`timescale 1ns/100ps
interface capture_mem_if #(parameter int AW = 7, parameter int DW = 8);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic rd_en;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport writer (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : capture_mem_if

//--- hdl/capture_ram.sv
// two capture buffers in one memory, registered read
`timescale 1ns/100ps
module capture_ram #(parameter int AW = 7, parameter int DW = 8)
(
   input wire logic mclk,
   input wire logic sys_rst,
   capture_mem_if.store port
);
   logic [DW-1:0] mem_q [2**AW];

   always_ff @(posedge mclk)
   begin
      if (port.wr_en)
         mem_q[port.wr_addr] <= port.wr_data;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         port.rd_data <= '0;
      else if (port.rd_en)
         port.rd_data <= mem_q[port.rd_addr];
   end
endmodule : capture_ram

//--- hdl/tck_gen.sv
// tck pulse generator, phases set by the divider
`timescale 1ns/100ps
module tck_gen #(parameter int DIV_W = 8)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [DIV_W-1:0] div,
   input wire logic start,
   output logic tck,
   output logic busy,
   output logic rise,
   output logic done
);
   logic [DIV_W-2:0] half;
   logic [DIV_W-2:0] half_m1;
   logic [DIV_W-2:0] cnt_reg;
   logic tck_reg;
   logic busy_reg;

   if (DIV_W < 2)
      $error("tck_gen needs a divider of two bits or more");

   // each phase lasts half the divider, never under one cycle
   assign half = (div[DIV_W-1:1] == '0) ? (DIV_W-1)'(1) : div[DIV_W-1:1];
   assign half_m1 = half - (DIV_W-1)'(1);
   assign rise = busy_reg && !tck_reg && cnt_reg == '0;
   assign done = busy_reg && tck_reg && cnt_reg == '0;
   assign tck = tck_reg;
   assign busy = busy_reg;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         busy_reg <= 1'b0;
         tck_reg <= 1'b0;
         cnt_reg <= '0;
      end
      else if (start && (!busy_reg || done))
      begin
         busy_reg <= 1'b1;
         tck_reg <= 1'b0;
         cnt_reg <= half_m1;
      end
      else if (busy_reg)
      begin
         if (cnt_reg != '0)
            cnt_reg <= cnt_reg - (DIV_W-1)'(1);
         else if (!tck_reg)
         begin
            tck_reg <= 1'b1;
            cnt_reg <= half_m1;
         end
         else
         begin
            tck_reg <= 1'b0;
            busy_reg <= 1'b0;
         end
      end
   end
endmodule : tck_gen

//--- hdl/usb_jtag_command_capture.sv
// nibble command interpreter, tdo capture buffers and control requests
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - each byte runs high nibble, then low
// - clock nibble sets tdi tms, one pulse
// - repeat reruns last command, scaled by chain
// - zero repeat: no pulse, still deepens chain
// - sample tdo only on capturing clocks
// - eight bits make a byte, earliest lsb
// - hand buffer at 64 bytes or flush
// - two buffers: one waits, one fills
// - swap only when host drained the waiting
// - both buffers full: capturing clocks stall, refuse bytes
// - repeated flushes give no empty packets
// - vendor request 0 loads tck divider
// - divider resets to 2
// - vendor request 1 drives lines directly
// - vendor request 2 returns live tdo
// - descriptor request 0x2000 returns capabilities
// - descriptor header: version, length, speed entry
// - speed entry: 8000, divisor 1 to 255
// - fastest tck is half bus clock
// - flush publishes all collected bits
module usb_jtag_command_capture #(parameter int DIV_W = usb_jtag_pkg::DIV_W)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   output logic pkt_avail,
   output logic [6:0] pkt_len,
   input wire logic pkt_rd,
   input wire logic [5:0] pkt_rd_index,
   output logic [7:0] pkt_rd_data,
   input wire logic pkt_done,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire logic [7:0] ctl_type,
   input wire logic [7:0] ctl_code,
   input wire logic [15:0] ctl_value,
   input wire logic [15:0] ctl_length,
   input wire logic [7:0] ctl_index,
   output logic [7:0] ctl_rd_data,
   output logic ctl_rd_ok,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst,
   output logic srst,
   input wire logic tdo
);
   if (DIV_W != 8)
      $error("divider register must be eight bits wide");

   usb_jtag_pkg::exec_state_e state_reg;
   logic [7:0] byte_reg;
   logic hi_sel_reg;
   logic [3:0] last_reg;
   logic [3:0] depth_reg;
   logic [usb_jtag_pkg::REP_W-1:0] rep_left_reg;
   logic [DIV_W-1:0] div_reg;
   logic tdi_reg, tms_reg, tck_man_reg, trst_reg, srst_reg;
   logic [7:0] shift_reg;
   logic [2:0] bitcnt_reg;
   logic [6:0] fill_cnt_reg;
   logic fill_buf_reg, pend_buf_reg, pend_valid_reg, flush_req_reg;
   logic [6:0] pend_len_reg;
   logic [7:0] ctl_rd_data_reg;
   logic ctl_rd_ok_reg;

   logic [3:0] nib;
   logic in_decode, is_clk, is_rst, is_rep, full, flush_fire, rep_go, adv;
   logic can_pulse, gen_start, gen_tck, gen_busy, gen_rise, gen_done, sample, xchg;
   logic [usb_jtag_pkg::REP_W-1:0] rep_n;
   logic [7:0] partial;
   logic set_div, set_io, is_tdo_rd, is_desc_rd;

   capture_mem_if #(.AW(usb_jtag_pkg::MEM_AW), .DW(usb_jtag_pkg::BYTE_W)) mem_bus ();

   capture_ram #(.AW(usb_jtag_pkg::MEM_AW), .DW(usb_jtag_pkg::BYTE_W)) u_ram
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .port(mem_bus.store)
   );

   // half bus clock at the smallest divider
   tck_gen #(.DIV_W(DIV_W)) u_tck
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .div(div_reg),
      .start(gen_start),
      .tck(gen_tck),
      .busy(gen_busy),
      .rise(gen_rise),
      .done(gen_done)
   );

   assign nib = hi_sel_reg ? byte_reg[7:4] : byte_reg[3:0];
   assign in_decode = state_reg == usb_jtag_pkg::ST_DECODE;
   assign is_clk = in_decode && !nib[usb_jtag_pkg::NIB_CLASS];
   assign is_rst = in_decode && nib[3:1] == usb_jtag_pkg::NIB_RST_TOP;
   assign is_rep = in_decode && nib[3:2] == usb_jtag_pkg::NIB_REP_TOP;
   assign full = fill_cnt_reg == usb_jtag_pkg::BUF_BYTES;
   assign rep_n = usb_jtag_pkg::rep_count(nib[1:0], depth_reg);
   // only a clock command is worth repeating
   assign rep_go = is_rep && !last_reg[usb_jtag_pkg::NIB_CLASS] && rep_n != '0;
   // flush waits only if a partial byte has no room
   assign flush_fire = in_decode && nib == usb_jtag_pkg::NIB_FLUSH && !(full && bitcnt_reg != 3'h0);
   assign can_pulse = !gen_busy || gen_done;
   // no capturing pulse while both buffers are full
   assign gen_start = state_reg == usb_jtag_pkg::ST_RUN && rep_left_reg != '0 && can_pulse
                      && !(last_reg[usb_jtag_pkg::NIB_CAP] && full);
   assign adv = (in_decode && nib[usb_jtag_pkg::NIB_CLASS] && !rep_go
                 && (nib != usb_jtag_pkg::NIB_FLUSH || flush_fire))
                || (state_reg == usb_jtag_pkg::ST_RUN && rep_left_reg == '0 && can_pulse);
   assign cmd_ready = state_reg == usb_jtag_pkg::ST_FETCH;

   // a stall only holds state, the next nibble follows
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_reg <= usb_jtag_pkg::ST_FETCH;
         byte_reg <= 8'h00;
         hi_sel_reg <= 1'b0;
         rep_left_reg <= '0;
      end
      else
      begin
         unique case (state_reg)
            usb_jtag_pkg::ST_FETCH:
            begin
               if (cmd_valid)
               begin
                  byte_reg <= cmd_data;
                  hi_sel_reg <= 1'b1;
                  state_reg <= usb_jtag_pkg::ST_DECODE;
               end
            end
            usb_jtag_pkg::ST_DECODE:
            begin
               if (is_clk || rep_go)
               begin
                  rep_left_reg <= is_clk ? usb_jtag_pkg::REP_W'(1) : rep_n;
                  state_reg <= usb_jtag_pkg::ST_RUN;
               end
               else if (adv && hi_sel_reg)
                  hi_sel_reg <= 1'b0;
               else if (adv)
                  state_reg <= usb_jtag_pkg::ST_FETCH;
            end
            usb_jtag_pkg::ST_RUN:
            begin
               if (gen_start)
                  rep_left_reg <= rep_left_reg - usb_jtag_pkg::REP_W'(1);
               else if (adv)
               begin
                  hi_sel_reg <= 1'b0;
                  state_reg <= hi_sel_reg ? usb_jtag_pkg::ST_DECODE : usb_jtag_pkg::ST_FETCH;
               end
            end
            default: state_reg <= usb_jtag_pkg::ST_FETCH;
         endcase
      end
   end

   // last command and repeat chain depth
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         last_reg <= usb_jtag_pkg::LAST_RESET;
         depth_reg <= 4'h0;
      end
      else if (is_rep)
      begin
         // a zero count still deepens the chain
         if (depth_reg != usb_jtag_pkg::REP_DEPTH_MAX)
            depth_reg <= depth_reg + 4'h1;
      end
      else if (in_decode && adv || is_clk)
      begin
         depth_reg <= 4'h0;
         last_reg <= nib;
      end
   end

   assign set_div = ctl_wr && ctl_type == usb_jtag_pkg::RT_VEND_OUT
                    && ctl_code == usb_jtag_pkg::REQ_SET_DIV && ctl_length == 16'h0000;
   assign set_io = ctl_wr && ctl_type == usb_jtag_pkg::RT_VEND_OUT
                   && ctl_code == usb_jtag_pkg::REQ_SET_IO && ctl_length == 16'h0000;

   // jtag lines and divider
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         tdi_reg <= 1'b0;
         tms_reg <= 1'b0;
         tck_man_reg <= 1'b0;
         trst_reg <= 1'b0;
         srst_reg <= 1'b0;
         div_reg <= usb_jtag_pkg::DIV_RESET;
      end
      else
      begin
         if (is_clk)
         begin
            tdi_reg <= nib[usb_jtag_pkg::NIB_TDI];
            tms_reg <= nib[usb_jtag_pkg::NIB_TMS];
         end
         if (is_rst)
            srst_reg <= nib[0];
         if (set_io)
         begin
            tdi_reg <= ctl_value[usb_jtag_pkg::IO_TDI];
            tms_reg <= ctl_value[usb_jtag_pkg::IO_TMS];
            tck_man_reg <= ctl_value[usb_jtag_pkg::IO_TCK];
            trst_reg <= ctl_value[usb_jtag_pkg::IO_TRST];
            srst_reg <= ctl_value[usb_jtag_pkg::IO_SRST];
         end
         if (set_div)
            div_reg <= ctl_value[DIV_W-1:0];
      end
   end

   assign tck = gen_busy ? gen_tck : tck_man_reg;
   assign tms = tms_reg;
   assign tdi = tdi_reg;
   assign trst = trst_reg;
   assign srst = srst_reg;

   assign sample = gen_rise && last_reg[usb_jtag_pkg::NIB_CAP];
   assign partial = shift_reg >> (4'h8 - {1'b0, bitcnt_reg});
   // byte written in the same cycle as the eighth bit
   assign mem_bus.wr_en = (sample && bitcnt_reg == 3'h7) || (flush_fire && bitcnt_reg != 3'h0);
   assign mem_bus.wr_data = sample ? {tdo, shift_reg[7:1]} : partial;
   assign mem_bus.wr_addr = {fill_buf_reg, fill_cnt_reg[usb_jtag_pkg::BUF_AW-1:0]};
   assign mem_bus.rd_en = pkt_rd;
   assign mem_bus.rd_addr = {pend_buf_reg, pkt_rd_index};
   // swap only with the waiting buffer drained
   assign xchg = !pend_valid_reg && !mem_bus.wr_en && fill_cnt_reg != 7'h00 && (full || flush_req_reg);

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         shift_reg <= 8'h00;
         bitcnt_reg <= 3'h0;
         fill_cnt_reg <= 7'h00;
         fill_buf_reg <= 1'b0;
         flush_req_reg <= 1'b0;
      end
      else
      begin
         if (sample)
         begin
            shift_reg <= {tdo, shift_reg[7:1]};
            bitcnt_reg <= bitcnt_reg + 3'h1;
         end
         if (flush_fire)
            bitcnt_reg <= 3'h0;
         // hand over at full or on flush
         if (xchg)
         begin
            fill_cnt_reg <= 7'h00;
            fill_buf_reg <= !fill_buf_reg;
            flush_req_reg <= 1'b0;
         end
         else if (mem_bus.wr_en)
            fill_cnt_reg <= fill_cnt_reg + 7'h01;
         // an empty or just swapped flush requests nothing
         if (flush_fire && !xchg && (fill_cnt_reg != 7'h00 || bitcnt_reg != 3'h0))
            flush_req_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         pend_valid_reg <= 1'b0;
         pend_buf_reg <= 1'b0;
         pend_len_reg <= 7'h00;
      end
      else if (xchg)
      begin
         pend_valid_reg <= 1'b1;
         pend_buf_reg <= fill_buf_reg;
         pend_len_reg <= fill_cnt_reg;
      end
      else if (pkt_done)
         pend_valid_reg <= 1'b0;
   end

   assign pkt_avail = pend_valid_reg;
   assign pkt_len = pend_len_reg;
   assign pkt_rd_data = mem_bus.rd_data;

   assign is_tdo_rd = ctl_type == usb_jtag_pkg::RT_VEND_IN && ctl_code == usb_jtag_pkg::REQ_GET_TDO;
   assign is_desc_rd = ctl_type == usb_jtag_pkg::RT_STD_IN && ctl_code == usb_jtag_pkg::REQ_GET_DESC
                       && ctl_value == usb_jtag_pkg::DESC_JTAG_CAP;

   always_ff @(posedge mclk)
   begin
      if (sys_rst || !ctl_rd)
      begin
         ctl_rd_data_reg <= 8'h00;
         ctl_rd_ok_reg <= 1'b0;
      end
      else if (is_tdo_rd)
      begin
         ctl_rd_data_reg <= {7'h00, tdo};
         ctl_rd_ok_reg <= 1'b1;
      end
      // capabilities descriptor, from the fixed table
      else if (is_desc_rd)
      begin
         ctl_rd_data_reg <= usb_jtag_pkg::desc_byte(ctl_index);
         ctl_rd_ok_reg <= ctl_index < usb_jtag_pkg::DESC_LEN;
      end
      else
      begin
         ctl_rd_data_reg <= 8'h00;
         ctl_rd_ok_reg <= 1'b0;
      end
   end

   assign ctl_rd_data = ctl_rd_data_reg;
   assign ctl_rd_ok = ctl_rd_ok_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_zero_rep;
      is_rep && nib[1:0] == 2'h0 && depth_reg < usb_jtag_pkg::REP_DEPTH_MAX;
   endsequence

   a_hi_first: assert property (cmd_valid && cmd_ready |=> in_decode && hi_sel_reg)
      else $error("byte not started at high nibble");
   a_clk_one_pulse: assert property (is_clk && !nib[2] |=> gen_start ##1 rep_left_reg == '0)
      else $error("clock nibble did not give one pulse");
   a_rep_load: assert property (rep_go |=> state_reg == usb_jtag_pkg::ST_RUN && rep_left_reg == $past(rep_n))
      else $error("repeat count wrong");
   a_rep_zero: assert property (s_zero_rep |=> depth_reg == $past(depth_reg) + 4'h1 && !gen_start)
      else $error("zero repeat misbehaved");
   a_no_cap_sample: assert property (gen_rise && !last_reg[2] |=> $stable(bitcnt_reg))
      else $error("sample without capture flag");
   a_byte_msb_late: assert property (sample && bitcnt_reg == 3'h7 |-> mem_bus.wr_en && mem_bus.wr_data[7] == tdo)
      else $error("capture byte order wrong");
   a_full_hand: assert property (full && !pend_valid_reg |=> pend_valid_reg && pend_len_reg == 7'h40)
      else $error("full buffer not handed over");
   a_stall_full: assert property (full && pend_valid_reg && last_reg[2] |-> !gen_start)
      else $error("capture pulse while both buffers full");
   a_no_empty: assert property ($rose(pend_valid_reg) |-> pend_len_reg != 7'h00)
      else $error("empty packet handed to host");
   a_div_load: assert property (set_div |=> div_reg == $past(ctl_value[7:0]))
      else $error("divider not loaded");
endmodule : usb_jtag_command_capture

//--- bench/jtag_target_model.sv
// jtag target stand-in: rotating tdo pattern, tck pulse count, tck high width
`timescale 1ns/100ps
module jtag_target_model #(parameter logic [15:0] PATTERN = 16'hb4d1)
(
   input wire logic mclk,
   input wire logic tck,
   output logic tdo,
   output int rise_count,
   output int high_width
);
   logic [15:0] shift_reg = PATTERN;
   int high_cnt_reg = 0;
   assign tdo = shift_reg[0];
   always @(posedge tck)
      rise_count <= rise_count + 1;
   // next bit only after a real pulse falls, not when tck first settles
   always @(negedge tck)
   begin
      if (rise_count > 0)
         shift_reg <= {shift_reg[0], shift_reg[15:1]};
   end
   // width of the last tck high phase in mclk cycles
   always @(posedge mclk)
   begin
      if (tck)
         high_cnt_reg <= high_cnt_reg + 1;
      else if (high_cnt_reg != 0)
      begin
         high_width <= high_cnt_reg;
         high_cnt_reg <= 0;
      end
   end
endmodule : jtag_target_model

//--- bench/testbench.sv
// self-checking bench for the usb to jtag command and capture block
`timescale 1ns/100ps
module testbench;
   typedef struct {logic [7:0] t; logic [7:0] c; logic [15:0] v; logic [15:0] l; logic [7:0] i; logic [7:0] d; logic ok;} row_s;
   localparam logic [15:0] PATTERN = 16'hb4d1;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_data = 8'h00;
   logic pkt_rd = 1'b0;
   logic [5:0] pkt_rd_index = 6'h00;
   logic pkt_done = 1'b0;
   logic ctl_wr = 1'b0;
   logic ctl_rd = 1'b0;
   logic [7:0] ctl_type = 8'h00;
   logic [7:0] ctl_code = 8'h00;
   logic [15:0] ctl_value = 16'h0000;
   logic [15:0] ctl_length = 16'h0000;
   logic [7:0] ctl_index = 8'h00;
   logic cmd_ready, pkt_avail, ctl_rd_ok, tck, tms, tdi, trst, srst, tdo;
   logic [6:0] pkt_len;
   logic [7:0] pkt_rd_data, ctl_rd_data;
   int rise_count, high_width, base;
   int fail_count = 0;
   int compares = 0;
   int pulses = 0;
   row_s rows [13];
   logic [7:0] desc_exp [11] = '{8'h01, 8'h0a, 8'h01, 8'h08, 8'h40, 8'h1f, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00};

   always #4 mclk = ~mclk;

   usb_jtag_command_capture dut (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .pkt_avail(pkt_avail), .pkt_len(pkt_len), .pkt_rd(pkt_rd), .pkt_rd_index(pkt_rd_index),
      .pkt_rd_data(pkt_rd_data), .pkt_done(pkt_done), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_type(ctl_type),
      .ctl_code(ctl_code), .ctl_value(ctl_value), .ctl_length(ctl_length), .ctl_index(ctl_index),
      .ctl_rd_data(ctl_rd_data), .ctl_rd_ok(ctl_rd_ok), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
      .srst(srst), .tdo(tdo));

   jtag_target_model #(.PATTERN(PATTERN)) target (.mclk(mclk), .tck(tck), .tdo(tdo), .rise_count(rise_count),
      .high_width(high_width));

   task automatic tally_and_finish();
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic give_up(input string name);
      chk(name, 1, 0);
      tally_and_finish();
   endtask : give_up

   function automatic logic [7:0] exp_byte(input int start, input int n);
      logic [7:0] b;
      b = 8'h00;
      for (int k = 0; k < n; k++)
         b[k] = PATTERN[(start + k) % 16];
      return b;
   endfunction : exp_byte

   // valid stays up across bytes, dropped after the last one is taken
   task automatic send(input logic [7:0] q [$]);
      int n;
      @(posedge mclk);
      foreach (q[j])
      begin
         n = 0;
         cmd_valid <= 1'b1;
         cmd_data <= q[j];
         do
         begin
            @(posedge mclk);
            n++;
         end while (cmd_ready !== 1'b1 && n < 5000);
         if (n >= 5000)
            give_up("cmd_ready");
      end
      cmd_valid <= 1'b0;
   endtask : send

   task automatic drain(input int len, input int start, input int last);
      int n;
      n = 0;
      while (pkt_avail !== 1'b1 && n < 20000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20000)
         give_up("pkt_avail");
      // host takes only packets with data
      chk("pkt_len", len, pkt_len);
      for (int j = 0; j < len; j++)
      begin
         @(posedge mclk);
         pkt_rd <= 1'b1;
         pkt_rd_index <= j[5:0];
         @(posedge mclk);
         pkt_rd <= 1'b0;
         #1 chk("pkt_rd_data", exp_byte(start + 8 * j, j == len - 1 ? last : 8), pkt_rd_data);
      end
      @(posedge mclk);
      pkt_done <= 1'b1;
      @(posedge mclk);
      pkt_done <= 1'b0;
      @(posedge mclk);
   endtask : drain

   task automatic ctl(input logic wr, input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
      input logic [15:0] l, input logic [7:0] i);
      @(posedge mclk);
      ctl_wr <= wr;
      ctl_rd <= ~wr;
      ctl_type <= t;
      ctl_code <= c;
      ctl_value <= v;
      ctl_length <= l;
      ctl_index <= i;
      @(posedge mclk);
      ctl_wr <= 1'b0;
      ctl_rd <= 1'b0;
      #1;
   endtask : ctl

   task automatic pulse_width(input int w);
      send('{8'h0a});
      repeat (20) @(posedge mclk);
      pulses++;
      chk("rise_count", pulses, rise_count);
      chk("high_width", w, high_width);
      chk("pkt_avail", 0, pkt_avail);
   endtask : pulse_width

   initial
   begin
      for (int i = 0; i < 11; i++)
         rows[i] = '{8'h80, 8'h06, 16'h2000, 16'h0100, i[7:0], desc_exp[i], i < 10};
      rows[11] = '{8'hc0, 8'h02, 16'h0000, 16'h0001, 8'h00, {7'h00, PATTERN[0]}, 1'b1};
      rows[12] = '{8'hc0, 8'h07, 16'h0000, 16'h0001, 8'h00, 8'h00, 1'b0};
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk("reset_outputs", 7'h40, {cmd_ready, pkt_avail, tck, tms, tdi, trst, srst});
      for (int i = 0; i < 13; i++)
      begin
         ctl(1'b0, rows[i].t, rows[i].c, rows[i].v, rows[i].l, rows[i].i);
         chk("ctl_rd_data", rows[i].d, ctl_rd_data);
         chk("ctl_rd_ok", rows[i].ok, ctl_rd_ok);
      end
      send('{8'h0d, 8'h5e, 8'hcf, 8'haa});
      drain(7, 2, 3);
      pulses = 53;
      chk("rise_count", pulses, rise_count);
      chk("tms_tdi", 2'b01, {tms, tdi});
      chk("high_width", 1, high_width);
      send('{8'haa, 8'haa});
      repeat (20) @(posedge mclk);
      chk("pkt_avail", 0, pkt_avail);
      send('{8'h44, 8'h44, 8'h44, 8'h44});
      repeat (20) @(posedge mclk);
      chk("pkt_avail", 0, pkt_avail);
      send('{8'haa});
      drain(1, 53, 8);
      pulses = 61;
      ctl(1'b1, 8'h40, 8'h00, 16'h0004, 16'h0000, 8'h00);
      ctl(1'b1, 8'h40, 8'h00, 16'h0008, 16'h0001, 8'h00);
      pulse_width(2);
      send('{8'h89});
      repeat (4) @(posedge mclk);
      chk("srst", 1, srst);
      ctl(1'b1, 8'h40, 8'h01, 16'h001b, 16'h0000, 8'h00);
      chk("direct_lines", 5'h1b, {srst, trst, tck, tms, tdi});
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk("rerun_reset", 7'h40, {cmd_ready, pkt_avail, tck, tms, tdi, trst, srst});
      pulse_width(1);
      base = pulses;
      send('{8'h4f, 8'hff, 8'hff, 8'h44});
      repeat (100) @(posedge mclk);
      chk("cmd_ready", 0, cmd_ready);
      chk("rise_count", base + 1024, rise_count);
      drain(64, base, 8);
      drain(64, base + 512, 8);
      send('{8'haa});
      drain(1, base + 1024, 2);
      chk("rise_count", base + 1026, rise_count);
      tally_and_finish();
   end
endmodule : testbench
